//--- core/alarm_status_bank.v
// Alarm present-status registers, interrupt enables and 1+1 protection fail/degrade exchange.
//
// Summary of operation
// - Seven receive enable registers from 0xb0 upward, one transmit enable at 0xe1.
// - Enable bits mirror source bits; source reaches interrupt only when enabled; reset 0.
// - Global source register holds one active-interrupt bit per source register.
// - Counter-overflow sources have no status bit; the counter serves as status.
// - Byte-change sources have no status bit; the received byte serves as status.
// - Regenerator status bit 2 shows loss of signal.
// - Regenerator status bit 1 shows loss of frame.
// - Regenerator status bit 0 shows out of frame.
// - Signal fail is line AIS or enabled excessive BER; drives fail pin.
// - A protection slave also drives signal fail on the bus fail line.
// - Line remote defect reads 1 when received K2 bits 2:0 equal 110.
// - Line AIS, bit 2 at 0xc1, reads 1 when K2 bits 2:0 equal 111.
// - Bit 3 at 0xc1 shows excessive B2 bit error rate.
// - Bit 1 at 0xc1 shows section trace string mismatch.
// - Bit 0 at 0xc1 shows section trace CRC-7 mismatch.
// - Protection status shows bus fail input in bit 3, degrade in bit 2.
// - Slave bus degrade output changes only on processor write to 0x21 bit 1 or to the slave bit at 0xf0.
// - Slave bus fail output follows every change of signal fail.
// - Bit 7 at 0xc4 is pointer loss: invalid pointer or checked SS not 10.
// - Bit 6 at 0xc4 mirrors the received new data flag.
// - Bit 5 at 0xc4 reads 1 when H1 and H2 are all ones.
// - Bit 2 at 0xc4 reads 1 when the C2 label is all ones.
`include "alarm_status_defines.vh"

module alarm_status_bank (
  input wire CLK_I,
  input wire RESETN_I,
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  input wire [63:0] RX_IRQ_SOURCE_I,
  input wire [7:0] TX_IRQ_SOURCE_I,
  input wire SIGNAL_LOSS_I,
  input wire FRAME_LOSS_I,
  input wire OUT_OF_FRAME_I,
  input wire [7:0] RX_K2_I,
  input wire HIGH_BER_I,
  input wire TRACE_MISMATCH_I,
  input wire TRACE_CRC_ERR_I,
  input wire PTR_INVALID_I,
  input wire [1:0] SS_BITS_I,
  input wire NEW_DATA_FLAG_I,
  input wire [7:0] PTR_H1_I,
  input wire [7:0] PTR_H2_I,
  input wire [7:0] SIGNAL_LABEL_I,
  input wire PROT_BUS_FAIL_LINE_I,
  input wire PROT_BUS_DEGRADE_LINE_I,
  output wire IRQ_O,
  output reg SIGNAL_FAIL_OUT_O,
  output reg PROT_BUS_FAIL_LINE_O,
  output reg PROT_BUS_DEGRADE_LINE_O,
  output wire PROT_BUS_OE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Detector and source inputs come from the same clock
  // domain; only the two protection bus lines arrive from another device.

  reg [1:0] prot_fail_sync_r;
  reg [1:0] prot_degrade_sync_r;

  // The lines may change at any moment relative to our clock, so only the
  // second flop of each pair is read; the first may still be settling.
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prot_fail_sync_r <= 2'h0;
    end else begin
      prot_fail_sync_r <= {prot_fail_sync_r[0], PROT_BUS_FAIL_LINE_I};
    end
  end

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prot_degrade_sync_r <= 2'h0;
    end else begin
      prot_degrade_sync_r <= {prot_degrade_sync_r[0], PROT_BUS_DEGRADE_LINE_I};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers.

  // Index 0..6 are the receive enables, index 7 is the transmit enable.
  reg [7:0] irq_enable_r [0:7];
  reg [7:0] local_config_r;
  reg degrade_request_bit_r;

  // Maps an enable register address to its slot: 0 to 6 receive, 7 transmit.
  // Slot 8 marks any other address, so one decoder serves both write and read.
  function [3:0] enable_slot;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_REGEN_IRQ_ENABLE: enable_slot = 4'h0;
        `OFS_REGEN_MUX_IRQ_ENABLE: enable_slot = 4'h1;
        `OFS_MUX_SECTION_IRQ_ENABLE: enable_slot = 4'h2;
        `OFS_PROTECTION_IRQ_ENABLE: enable_slot = 4'h3;
        `OFS_ADAPTATION_PATH_IRQ_ENABLE: enable_slot = 4'h4;
        `OFS_PATH_TERM_IRQ_ENABLE: enable_slot = 4'h5;
        `OFS_RETIMING_IRQ_ENABLE: enable_slot = 4'h6;
        `OFS_TRANSMIT_IRQ_ENABLE: enable_slot = 4'h7;
        default: enable_slot = 4'h8;
      endcase
    end
  endfunction

  // True when the low three bits of a received byte carry the given code.
  function k2_code_match;
    input [7:0] k2;
    input [2:0] code;
    begin
      k2_code_match = (k2[2:0] == code);
    end
  endfunction

  // True when a received byte is all ones, the usual alarm fill pattern.
  function all_ones;
    input [7:0] value;
    begin
      all_ones = (value == 8'hff);
    end
  endfunction

  wire [3:0] bus_slot = enable_slot(ADDR_I);
  wire bus_hits_enable = ~bus_slot[3];

  wire slave_mode = local_config_r[`BIT_CFG_SLAVE];

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_enable_r[0] <= `ENABLE_RESET;
      irq_enable_r[1] <= `ENABLE_RESET;
      irq_enable_r[2] <= `ENABLE_RESET;
      irq_enable_r[3] <= `ENABLE_RESET;
      irq_enable_r[4] <= `ENABLE_RESET;
      irq_enable_r[5] <= `ENABLE_RESET;
      irq_enable_r[6] <= `ENABLE_RESET;
      irq_enable_r[7] <= `ENABLE_RESET;
      local_config_r <= `CONFIG_RESET;
      degrade_request_bit_r <= 1'b0;
    end else if (WR_I) begin
      if (bus_hits_enable) begin
        irq_enable_r[bus_slot[2:0]] <= WDATA_I;
      end else begin
        case (ADDR_I)
          `OFS_LOCAL_CONFIG: begin
            local_config_r <= {5'h00, WDATA_I[2:0]};
          end
          `OFS_PROT_CONTROL: begin
            degrade_request_bit_r <= WDATA_I[`BIT_DEGRADE_REQUEST];
          end
          default: begin
            // Writes to status registers and unmapped addresses are dropped.
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Present status, continuous and unlatched.

  wire signal_loss_status = SIGNAL_LOSS_I;
  wire frame_loss_status = FRAME_LOSS_I;
  wire out_of_frame_status = OUT_OF_FRAME_I;
  wire line_remote_defect_status = k2_code_match(RX_K2_I, `K2_REMOTE_DEFECT);
  wire line_ais_status = k2_code_match(RX_K2_I, `K2_LINE_AIS);
  wire excessive_ber_status = HIGH_BER_I;
  wire section_trace_mismatch_status = TRACE_MISMATCH_I;
  wire section_trace_crc_status = TRACE_CRC_ERR_I;
  wire ais_on_high_ber_enable = local_config_r[`BIT_CFG_AIS_ON_BER];
  wire signal_fail_status = line_ais_status
    | (ais_on_high_ber_enable & excessive_ber_status);
  wire ss_bit_check_enable = local_config_r[`BIT_CFG_SS_CHECK];
  wire pointer_loss_status = PTR_INVALID_I
    | (ss_bit_check_enable & (SS_BITS_I != `SS_EXPECTED));
  wire new_data_flag_status = NEW_DATA_FLAG_I;
  wire unit_ais_status = all_ones(PTR_H1_I) & all_ones(PTR_H2_I);
  wire container_ais_status = all_ones(SIGNAL_LABEL_I);
  wire prot_bus_fail_status = prot_fail_sync_r[1];
  wire prot_bus_degrade_status = prot_degrade_sync_r[1];

  // Counter-overflow and byte-change sources have no bit here: software
  // reads the counter or the received byte instead.
  // Every bit not set below is reserved and reads zero.
  reg [7:0] regen_status;
  reg [7:0] regen_mux_status;
  reg [7:0] protection_status;
  reg [7:0] adaptation_path_status;

  always @* begin
    regen_status = 8'h00;
    regen_status[`BIT_SIG_LOSS] = signal_loss_status;
    regen_status[`BIT_FRAME_LOSS] = frame_loss_status;
    regen_status[`BIT_OOF] = out_of_frame_status;
  end

  always @* begin
    regen_mux_status = 8'h00;
    regen_mux_status[`BIT_SIG_FAIL] = signal_fail_status;
    regen_mux_status[`BIT_REMOTE_DEFECT] = line_remote_defect_status;
    regen_mux_status[`BIT_HIGH_BER] = excessive_ber_status;
    regen_mux_status[`BIT_LINE_AIS] = line_ais_status;
    regen_mux_status[`BIT_TRACE_MISMATCH] = section_trace_mismatch_status;
    regen_mux_status[`BIT_TRACE_CRC] = section_trace_crc_status;
  end

  // These two bits lag the pins by the synchroniser; they only matter on a
  // protection main, but are shown in every role.
  always @* begin
    protection_status = 8'h00;
    protection_status[`BIT_PROT_FAIL] = prot_bus_fail_status;
    protection_status[`BIT_PROT_DEGRADE] = prot_bus_degrade_status;
  end

  always @* begin
    adaptation_path_status = 8'h00;
    adaptation_path_status[`BIT_PTR_LOSS] = pointer_loss_status;
    adaptation_path_status[`BIT_NEW_DATA] = new_data_flag_status;
    adaptation_path_status[`BIT_UNIT_AIS] = unit_ais_status;
    adaptation_path_status[`BIT_CONTAINER_AIS] = container_ais_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating and global source.

  // The global flags are not gated by the enables, so software can poll the
  // sources with every enable off; only the pin honours the enables.
  wire [7:0] global_irq_source;
  wire [7:0] enabled_any;

  assign global_irq_source[0] = |RX_IRQ_SOURCE_I[7:0];
  assign global_irq_source[1] = |RX_IRQ_SOURCE_I[15:8];
  assign global_irq_source[2] = |RX_IRQ_SOURCE_I[23:16];
  assign global_irq_source[3] = |RX_IRQ_SOURCE_I[31:24];
  assign global_irq_source[4] = |RX_IRQ_SOURCE_I[39:32];
  assign global_irq_source[5] = |RX_IRQ_SOURCE_I[47:40];
  assign global_irq_source[6] = |RX_IRQ_SOURCE_I[55:48];
  assign global_irq_source[7] = |TX_IRQ_SOURCE_I;

  assign enabled_any[0] = |(RX_IRQ_SOURCE_I[7:0] & irq_enable_r[0]);
  assign enabled_any[1] = |(RX_IRQ_SOURCE_I[15:8] & irq_enable_r[1]);
  assign enabled_any[2] = |(RX_IRQ_SOURCE_I[23:16] & irq_enable_r[2]);
  assign enabled_any[3] = |(RX_IRQ_SOURCE_I[31:24] & irq_enable_r[3]);
  assign enabled_any[4] = |(RX_IRQ_SOURCE_I[39:32] & irq_enable_r[4]);
  assign enabled_any[5] = |(RX_IRQ_SOURCE_I[47:40] & irq_enable_r[5]);
  assign enabled_any[6] = |(RX_IRQ_SOURCE_I[55:48] & irq_enable_r[6]);
  assign enabled_any[7] = |(TX_IRQ_SOURCE_I & irq_enable_r[7]);
  // The interrupt pin is combinational so it clears as soon as the source does.
  assign IRQ_O = |enabled_any;

  ////////////////////////////////////////////////////////////////////////////
  // Protection exchange. The bus lines are driven only by a slave; a master
  // listens, so the enable keeps two masters from fighting on the wire.

  assign PROT_BUS_OE_O = slave_mode;

  // The fail pin follows signal fail in either role.
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SIGNAL_FAIL_OUT_O <= 1'b0;
    end else begin
      SIGNAL_FAIL_OUT_O <= signal_fail_status;
    end
  end

  // A slave copies every change of signal fail onto the bus one cycle later.
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PROT_BUS_FAIL_LINE_O <= 1'b0;
    end else begin
      PROT_BUS_FAIL_LINE_O <= slave_mode & signal_fail_status;
    end
  end

  // The degrade line moves only once a processor write has landed in the
  // request bit or the slave bit; the block never decides degrade on its own.
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PROT_BUS_DEGRADE_LINE_O <= 1'b0;
    end else begin
      PROT_BUS_DEGRADE_LINE_O <= slave_mode & degrade_request_bit_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe, no side effects.

  reg [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = 8'h00;
    if (bus_hits_enable) begin
      rdata_nxt = irq_enable_r[bus_slot[2:0]];
    end else begin
      case (ADDR_I)
        `OFS_REGEN_STATUS: rdata_nxt = regen_status;
        `OFS_REGEN_MUX_STATUS: rdata_nxt = regen_mux_status;
        `OFS_PROTECTION_STATUS: rdata_nxt = protection_status;
        `OFS_ADAPTATION_PATH_STATUS: rdata_nxt = adaptation_path_status;
        `OFS_GLOBAL_IRQ_SOURCE: rdata_nxt = global_irq_source;
        `OFS_LOCAL_CONFIG: rdata_nxt = local_config_r;
        `OFS_PROT_CONTROL: rdata_nxt = {6'h00, degrade_request_bit_r, 1'b0};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      RDATA_O <= rdata_nxt;
    end else begin
      RDATA_O <= 8'h00;
    end
  end

endmodule // alarm_status_bank

//--- core/alarm_status_defines.vh
// Register offsets, field positions and reset values of the alarm status and enable bank.
`ifndef ALARM_STATUS_DEFINES_VH
`define ALARM_STATUS_DEFINES_VH
`define OFS_REGEN_IRQ_ENABLE 8'hb0
`define OFS_REGEN_MUX_IRQ_ENABLE 8'hb1
`define OFS_MUX_SECTION_IRQ_ENABLE 8'hb2
`define OFS_PROTECTION_IRQ_ENABLE 8'hb3
`define OFS_ADAPTATION_PATH_IRQ_ENABLE 8'hb4
`define OFS_PATH_TERM_IRQ_ENABLE 8'hb5
`define OFS_RETIMING_IRQ_ENABLE 8'hb6
`define OFS_REGEN_STATUS 8'hc0
`define OFS_REGEN_MUX_STATUS 8'hc1
`define OFS_PROTECTION_STATUS 8'hc3
`define OFS_ADAPTATION_PATH_STATUS 8'hc4
`define OFS_GLOBAL_IRQ_SOURCE 8'hd1
`define OFS_TRANSMIT_IRQ_ENABLE 8'he1
`define OFS_PROT_CONTROL 8'h21
`define OFS_LOCAL_CONFIG 8'hf0
`define ENABLE_RESET 8'h00
`define CONFIG_RESET 8'h00
`define BIT_SIG_LOSS 2
`define BIT_FRAME_LOSS 1
`define BIT_OOF 0
`define BIT_SIG_FAIL 5
`define BIT_REMOTE_DEFECT 4
`define BIT_HIGH_BER 3
`define BIT_LINE_AIS 2
`define BIT_TRACE_MISMATCH 1
`define BIT_TRACE_CRC 0
`define BIT_PROT_FAIL 3
`define BIT_PROT_DEGRADE 2
`define BIT_PTR_LOSS 7
`define BIT_NEW_DATA 6
`define BIT_UNIT_AIS 5
`define BIT_CONTAINER_AIS 2
`define BIT_DEGRADE_REQUEST 1
`define BIT_CFG_SLAVE 0
`define BIT_CFG_AIS_ON_BER 1
`define BIT_CFG_SS_CHECK 2
`define K2_REMOTE_DEFECT 3'h6
`define K2_LINE_AIS 3'h7
`define SS_EXPECTED 2'h2
`define NUM_SOURCES 8
`endif

//--- testbench/alarm_status_bank_bench.sv
// Self-checking bench of the alarm status and enable bank.
module alarm_status_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, los = 0, lof = 0, oof = 0, ber = 0, tmm = 0, tcrc = 0, pinv = 0;
  logic ndf = 0, pfi = 0, pdi = 0, irq, sfo, pfo, pdo, oe, wr, rd;
  logic [1:0] ss = 0;
  logic [7:0] k2 = 0, h1 = 0, h2 = 0, c2 = 0, tx = 0, addr, wdata, rdata, d, v, cfg;
  logic [63:0] rx = 0;
  logic [7:0] ens [8] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'he1};
  int err_count = 0, n_compared = 0, b;
  always #2.5 clk = ~clk;
  alarm_status_bank u_alarm_status_bank (.CLK_I(clk), .RESETN_I(rstn), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RX_IRQ_SOURCE_I(rx),
    .TX_IRQ_SOURCE_I(tx), .SIGNAL_LOSS_I(los), .FRAME_LOSS_I(lof), .OUT_OF_FRAME_I(oof),
    .RX_K2_I(k2), .HIGH_BER_I(ber), .TRACE_MISMATCH_I(tmm), .TRACE_CRC_ERR_I(tcrc),
    .PTR_INVALID_I(pinv), .SS_BITS_I(ss), .NEW_DATA_FLAG_I(ndf), .PTR_H1_I(h1), .PTR_H2_I(h2),
    .SIGNAL_LABEL_I(c2), .PROT_BUS_FAIL_LINE_I(pfi), .PROT_BUS_DEGRADE_LINE_I(pdi),
    .IRQ_O(irq), .SIGNAL_FAIL_OUT_O(sfo), .PROT_BUS_FAIL_LINE_O(pfo),
    .PROT_BUS_DEGRADE_LINE_O(pdo), .PROT_BUS_OE_O(oe));
  host_model u_host_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function logic [7:0] st(input logic [7:0] a);
    case (a)
      8'hc0: st = {5'h00, los, lof, oof};
      8'hc1: st = {2'h0, k2[2:0] == 3'h7 | (cfg[1] & ber), k2[2:0] == 3'h6, ber,
        k2[2:0] == 3'h7, tmm, tcrc};
      8'hc4: st = {pinv | (cfg[2] & ss != 2'h2), ndf, {h1, h2} == 16'hffff, 2'h0,
        c2 == 8'hff, 2'h0};
      default: st = 8'h00;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    err_count++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h631b));
    cfg = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    foreach (ens[i]) begin
      u_host_model.rd(ens[i], d); cmp(d, 8'h00);
      v = $urandom;
      u_host_model.wr(ens[i], v);
      u_host_model.rd(ens[i], d); cmp(d, v);
    end
    u_host_model.rd(8'hb7, d); cmp(d, 8'h00);
    for (int g = 0; g < 8; g++) begin
      b = $urandom_range(7);
      @(posedge clk);
      rx <= (g < 7) ? 64'h1 << (8 * g + b) : 64'h0;
      tx <= (g == 7) ? 8'h01 << b : 8'h00;
      u_host_model.wr(ens[g], 8'h01 << b);
      @(posedge clk); #1 cmp({7'h00, irq}, 8'h01);
      u_host_model.rd(8'hd1, d); cmp(d, 8'h01 << g);
      u_host_model.wr(ens[g], ~(8'h01 << b));
      @(posedge clk); #1 cmp({7'h00, irq}, 8'h00);
    end
    repeat (40) begin
      cfg = $urandom_range(7);
      u_host_model.wr(8'hf0, cfg);
      @(posedge clk);
      {los, lof, oof, ber, tmm, tcrc, pinv, ndf} <= $urandom;
      {ss, k2} <= $urandom;
      c2 <= $urandom_range(1) ? 8'hff : 8'h3c;
      h1 <= $urandom_range(1) ? 8'hff : 8'($urandom);
      h2 <= $urandom_range(1) ? 8'hff : 8'($urandom);
      u_host_model.wr(8'hc0, 8'hff);
      u_host_model.rd(8'hc0, d); cmp(d, st(8'hc0));
      u_host_model.rd(8'hc1, d); cmp(d, st(8'hc1));
      u_host_model.rd(8'hc4, d); cmp(d, st(8'hc4));
    end
    u_host_model.wr(8'hf0, 8'h01);
    k2 <= 8'h07;
    repeat (2) @(posedge clk);
    #1 cmp({5'h00, oe, sfo, pfo}, 8'h07);
    cmp({7'h00, pdo}, 8'h00);
    u_host_model.wr(8'h21, 8'h02);
    repeat (3) @(posedge clk);
    #1 cmp({7'h00, pdo}, 8'h01);
    @(posedge clk);
    {pfi, pdi} <= 2'h2;
    repeat (3) @(posedge clk);
    u_host_model.rd(8'hc3, d); cmp(d, 8'h08);
    @(posedge clk);
    {pfi, pdi} <= 2'h1;
    repeat (3) @(posedge clk);
    u_host_model.rd(8'hc3, d); cmp(d, 8'h04);
    u_host_model.wr(8'hf0, 8'h00);
    repeat (2) @(posedge clk);
    #1 cmp({5'h00, oe, pfo, pdo}, 8'h00);
    end_sim;
  end
endmodule // alarm_status_bank_bench

//--- testbench/alarm_status_bank_monitor.sv
// Concurrent checks on the ports of the alarm status bank.
module alarm_status_bank_monitor (
  input wire CLK_I, RESETN_I, WR_I, RD_I, IRQ_O,
  input wire [7:0] ADDR_I, RDATA_O, RX_K2_I, PTR_H1_I, PTR_H2_I, SIGNAL_LABEL_I,
  input wire SIGNAL_LOSS_I, FRAME_LOSS_I, OUT_OF_FRAME_I, HIGH_BER_I, NEW_DATA_FLAG_I,
  input wire TRACE_MISMATCH_I, TRACE_CRC_ERR_I, SIGNAL_FAIL_OUT_O,
  input wire PROT_BUS_FAIL_LINE_O, PROT_BUS_DEGRADE_LINE_O, PROT_BUS_OE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_sf_set;
    RX_K2_I[2:0] == 3'h7 |=> SIGNAL_FAIL_OUT_O;
  endproperty
  a_sf_set: assert property (p_sf_set) else $error("fail out low on line AIS");
  property p_sf_clr;
    RX_K2_I[2:0] != 3'h7 && !HIGH_BER_I |=> !SIGNAL_FAIL_OUT_O;
  endproperty
  a_sf_clr: assert property (p_sf_clr) else $error("fail out high without cause");
  property p_slave_fail;
    PROT_BUS_OE_O && $past(PROT_BUS_OE_O) |-> PROT_BUS_FAIL_LINE_O == SIGNAL_FAIL_OUT_O;
  endproperty
  a_slave_fail: assert property (p_slave_fail) else $error("bus fail line lags");
  property p_master_quiet;
    !PROT_BUS_OE_O && !$past(PROT_BUS_OE_O) |-> !PROT_BUS_FAIL_LINE_O && !PROT_BUS_DEGRADE_LINE_O;
  endproperty
  a_master_quiet: assert property (p_master_quiet) else $error("master drives bus");
  property p_degrade_hold;
    $changed(PROT_BUS_DEGRADE_LINE_O) |-> $past(WR_I) || $past(WR_I, 2) || $past(WR_I, 3);
  endproperty
  a_degrade_hold: assert property (p_degrade_hold) else $error("degrade moved alone");
  property p_rd_idle;
    !$past(RD_I) |-> RDATA_O == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_regen;
    RD_I && ADDR_I == 8'hc0 |=> RDATA_O == {5'h00, $past(SIGNAL_LOSS_I),
      $past(FRAME_LOSS_I), $past(OUT_OF_FRAME_I)};
  endproperty
  a_regen: assert property (p_regen) else $error("regen status wrong");
  sequence s_rd_c1;
    RD_I && ADDR_I == 8'hc1;
  endsequence
  property p_line;
    s_rd_c1 |=> RDATA_O[4:0] == {$past(RX_K2_I[2:0] == 3'h6), $past(HIGH_BER_I),
      $past(RX_K2_I[2:0] == 3'h7), $past(TRACE_MISMATCH_I), $past(TRACE_CRC_ERR_I)};
  endproperty
  a_line: assert property (p_line) else $error("line status wrong");
  property p_path;
    RD_I && ADDR_I == 8'hc4 |=> RDATA_O[6:0] == {$past(NEW_DATA_FLAG_I),
      $past({PTR_H1_I, PTR_H2_I} == 16'hffff), 2'h0, $past(SIGNAL_LABEL_I == 8'hff), 2'h0};
  endproperty
  a_path: assert property (p_path) else $error("path status wrong");
  c_irq: cover property (IRQ_O);
  c_fail: cover property (PROT_BUS_FAIL_LINE_O);
  c_degrade: cover property ($rose(PROT_BUS_DEGRADE_LINE_O));
endmodule // alarm_status_bank_monitor

bind alarm_status_bank alarm_status_bank_monitor u_alarm_status_bank_monitor (.*);

//--- testbench/host_model.sv
// Microcontroller model that issues single-cycle register strobes.
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 v = rdata_i;
  endtask
endmodule // host_model
